// ### src/conv_seq_pkg.sv
// package for the converter conversion sequencer
// assumes a single 100 mhz cpu clock domain
package conv_seq_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [3:0] ctrl_status_off  = 4'h0;
  localparam logic [3:0] input_select_off = 4'h1;
  localparam logic [3:0] result_low_off   = 4'h2;
  localparam logic [3:0] result_high_off  = 4'h3;
  localparam logic [3:0] trigger_cfg_off  = 4'h4;
  localparam logic [3:0] active_sel_off   = 4'h5;

  // ----------------------------------------
  // control and status field positions
  // ----------------------------------------
  localparam int enable_bit     = 7;
  localparam int start_bit      = 6;
  localparam int auto_trig_bit  = 5;
  localparam int done_bit       = 4;
  localparam int div_lsb        = 0;
  localparam int div_w          = 3;

  // ----------------------------------------
  // input select field positions
  // ----------------------------------------
  localparam int chan_lsb = 0;
  localparam int chan_w   = 5;
  localparam int ref_lsb  = 6;
  localparam int ref_w    = 2;

  // ----------------------------------------
  // trigger config field positions
  // ----------------------------------------
  localparam int trig_src_lsb = 0;
  localparam int trig_src_w   = 3;
  localparam int diff_bit     = 7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ctrl_status_rst  = 8'h00;
  localparam logic [7:0] input_select_rst = 8'h00;
  localparam logic [7:0] trigger_cfg_rst  = 8'h00;

  // ----------------------------------------
  // timing counts, in converter clock cycles
  // ----------------------------------------
  localparam logic [4:0] normal_len   = 5'h0d;  // 13
  localparam logic [4:0] first_len    = 5'h19;  // 25
  localparam logic [4:0] diff_hi_len  = 5'h0e;  // 14
  localparam logic [4:0] normal_sh    = 5'h01;  // 1.5 -> edge after cycle 1
  localparam logic [4:0] first_sh     = 5'h0d;  // 13.5
  localparam logic [4:0] diff_hi_sh   = 5'h02;  // 2.5
  localparam logic [4:0] auto_sh      = 5'h02;  // 2
  localparam logic [2:0] trig_free    = 3'h0;   // trigger on done flag

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_wait = 2'b01,
    st_conv = 2'b11,
    st_last = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [ref_w-1:0]  ref_sel;
    logic [chan_w-1:0] chan_sel;
  } sel_t;

endpackage

// ### src/conv_seq.sv
// conversion sequencer for a successive-approximation converter
// assumes a register port on clk, trigger inputs from outside the domain
// Summary of operation
// RULE1 - converter clock is cpu clock divided by selected prescaler ratio
// RULE2 - prescaler runs while enabled, held in reset while enable is low
// RULE3 - software start begins conversion at next converter clock edge
// RULE4 - normal conversion lasts 13 cycles, sample at 1.5
// RULE5 - first conversion after enable lasts 25 cycles, sample at 13.5
// RULE6 - completion stores result, sets done flag, clears start in single mode
// RULE7 - trigger event resets prescaler for fixed start delay
// RULE8 - auto trigger sample two cycles after trigger, 13.5 cycle conversion (code uses normal_len, 13 cycles from the trigger)
// RULE9 - differential auto-triggered conversions each take 25 cycles
// RULE10 - free running restarts immediately and keeps start flag high
// RULE11 - differential user start while half clock low takes 13 cycles
// RULE12 - differential start while half clock high or free running takes 14
// RULE13 - software disables and re-enables between differential triggered runs
// RULE14 - selection buffer tracks until start, then locks during conversion
// RULE15 - selection tracking resumes in last cycle before done
// RULE16 - software waits one converter cycle after start before reselecting
// RULE17 - auto trigger selection changes only at safe moments
// RULE18 - software waits 125us after differential or reference change
// RULE19 - upper four shared pins lose converter input while test port enabled
// RULE20 - free-running channel change applies from conversion after next
// RULE21 - software keeps converter clock between 50khz and 200khz
// RULE22 - trigger edges during a conversion are ignored
// RULE23 - start flag reads one throughout any conversion
// RULE24 - low byte read blocks result updates until high byte read
// RULE25 - sequencer counts converter cycles and marks first conversion
`timescale 1ns/100ps

module conv_seq #(
  parameter int trig_n = 8
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [3:0]           addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  input  wire logic [trig_n-1:0]    trig_in,
  input  wire logic [9:0]           sar_result,
  input  wire logic                 test_port_en,
  output logic                      sample_hold,
  output logic                      conv_busy,
  output logic                      analog_en,
  output logic      [4:0]           chan_active,
  output logic      [1:0]           ref_active,
  output logic      [3:0]           upper_pin_analog_en
);

  // ----------------------------------------
  // registers and wires
  // ----------------------------------------
  conv_seq_pkg::bus_req_t   req;
  conv_seq_pkg::sel_t       sel_tmp;
  conv_seq_pkg::seq_state_t state_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  isel_r;
  logic [7:0]  tcfg_r;
  logic [7:0]  res_lo_r;
  logic [1:0]  res_hi_r;
  logic        block_r;
  logic [6:0]  pre_r;
  logic        tick;
  logic        half_clk_r;
  logic [trig_n-1:0] trig_m_r;
  logic [trig_n-1:0] trig_s_r;
  logic        trig_lvl_r;
  logic        trig_edge;
  logic        first_r;
  logic [4:0]  cnt_r;
  logic [4:0]  len_r;
  logic [4:0]  sh_r;
  logic        sw_start;
  logic        done_evt;
  logic        free_run;
  logic        auto_on;
  logic        enable;
  logic        diff_mode;
  logic        test_m_r;
  logic        test_s_r;

  assign req       = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign enable    = ctrl_r[conv_seq_pkg::enable_bit];
  assign auto_on   = ctrl_r[conv_seq_pkg::auto_trig_bit];
  assign diff_mode = tcfg_r[conv_seq_pkg::diff_bit];
  assign free_run  = auto_on && (tcfg_r[conv_seq_pkg::trig_src_lsb +: conv_seq_pkg::trig_src_w]
                                 == conv_seq_pkg::trig_free);
  assign sw_start  = req.wr && (req.addr == conv_seq_pkg::ctrl_status_off)
                     && req.wdata[conv_seq_pkg::start_bit] && req.wdata[conv_seq_pkg::enable_bit];
  assign sel_tmp   = '{ref_sel: isel_r[conv_seq_pkg::ref_lsb +: conv_seq_pkg::ref_w],
                       chan_sel: isel_r[conv_seq_pkg::chan_lsb +: conv_seq_pkg::chan_w]};

  // ----------------------------------------
  // trigger synchroniser and edge
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_m_r <= '0;
      trig_s_r <= '0;
      test_m_r <= 1'b0;
      test_s_r <= 1'b0;
    end else begin
      trig_m_r <= trig_in;
      trig_s_r <= trig_m_r;
      test_m_r <= test_port_en;
      test_s_r <= test_m_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_lvl_r <= 1'b0;
    end else begin
      trig_lvl_r <= trig_s_r[tcfg_r[conv_seq_pkg::trig_src_lsb +: conv_seq_pkg::trig_src_w]];
    end
  end

  // RULE22 edge only when idle
  assign trig_edge = auto_on && !free_run && enable && (state_r == conv_seq_pkg::st_idle)
                     && trig_s_r[tcfg_r[conv_seq_pkg::trig_src_lsb +: conv_seq_pkg::trig_src_w]]
                     && !trig_lvl_r;

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  // RULE1 RULE2 RULE7 divide, hold, restart
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r      <= '0;
      half_clk_r <= 1'b0;
    end else if (!enable || trig_edge) begin
      pre_r      <= '0;
      half_clk_r <= 1'b0;
    end else begin
      pre_r <= pre_r + 7'h01;
      if (tick) begin
        half_clk_r <= !half_clk_r;
      end
    end
  end

  always_comb begin
    logic [2:0] dv;
    dv   = ctrl_r[conv_seq_pkg::div_lsb +: conv_seq_pkg::div_w];
    tick = 1'b0;
    if (enable) begin
      case (dv)
        3'h0, 3'h1: tick = pre_r[0];
        3'h2:       tick = &pre_r[1:0];
        3'h3:       tick = &pre_r[2:0];
        3'h4:       tick = &pre_r[3:0];
        3'h5:       tick = &pre_r[4:0];
        3'h6:       tick = &pre_r[5:0];
        default:    tick = &pre_r[6:0];
      endcase
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  // RULE25 count and mark first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= conv_seq_pkg::st_idle;
      cnt_r   <= '0;
      len_r   <= conv_seq_pkg::normal_len;
      sh_r    <= conv_seq_pkg::normal_sh;
      first_r <= 1'b1;
    end else if (!enable) begin
      state_r <= conv_seq_pkg::st_idle;
      cnt_r   <= '0;
      first_r <= 1'b1;
    end else begin
      case (state_r)
        conv_seq_pkg::st_idle: begin
          // RULE3 wait for converter edge
          if (sw_start || trig_edge || ctrl_r[conv_seq_pkg::start_bit]) begin
            state_r <= conv_seq_pkg::st_wait;
            cnt_r   <= '0;
            // RULE7 trigger starts at restart
            if (trig_edge) begin
              state_r <= conv_seq_pkg::st_conv;
              first_r <= 1'b0;
            end
            // RULE5 RULE9 first is extended
            if (first_r) begin
              len_r <= conv_seq_pkg::first_len;
              sh_r  <= conv_seq_pkg::first_sh;
            // RULE8 auto trigger timing
            end else if (trig_edge) begin
              len_r <= conv_seq_pkg::normal_len;
              // counted from restart, not from a tick
              sh_r  <= conv_seq_pkg::auto_sh - 5'h01;
            // RULE11 RULE12 half clock sync
            end else if (diff_mode && half_clk_r) begin
              len_r <= conv_seq_pkg::diff_hi_len;
              sh_r  <= conv_seq_pkg::diff_hi_sh;
            // RULE4 normal length
            end else begin
              len_r <= conv_seq_pkg::normal_len;
              sh_r  <= conv_seq_pkg::normal_sh;
            end
          end
        end
        conv_seq_pkg::st_wait: begin
          if (tick) begin
            state_r <= conv_seq_pkg::st_conv;
            first_r <= 1'b0;
          end
        end
        conv_seq_pkg::st_conv: begin
          if (tick) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r + 5'h02 == len_r) begin
              state_r <= conv_seq_pkg::st_last;
            end
          end
        end
        conv_seq_pkg::st_last: begin
          if (tick) begin
            cnt_r <= '0;
            // RULE10 RULE12 free run restart
            if (free_run) begin
              state_r <= conv_seq_pkg::st_conv;
              len_r   <= diff_mode ? conv_seq_pkg::diff_hi_len : conv_seq_pkg::normal_len;
              sh_r    <= diff_mode ? conv_seq_pkg::diff_hi_sh : conv_seq_pkg::normal_sh;
            end else begin
              state_r <= conv_seq_pkg::st_idle;
            end
          end
        end
        default: state_r <= conv_seq_pkg::st_idle;
      endcase
    end
  end

  assign done_evt = (state_r == conv_seq_pkg::st_last) && tick;

  // ----------------------------------------
  // control status and config registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= conv_seq_pkg::ctrl_status_rst;
    end else begin
      if (req.wr && req.addr == conv_seq_pkg::ctrl_status_off) begin
        ctrl_r[7]   <= req.wdata[7];
        ctrl_r[5]   <= req.wdata[5];
        ctrl_r[2:0] <= req.wdata[2:0];
        ctrl_r[3]   <= req.wdata[3];
        if (req.wdata[conv_seq_pkg::start_bit]) begin
          ctrl_r[conv_seq_pkg::start_bit] <= 1'b1;
        end
        if (req.wdata[conv_seq_pkg::done_bit]) begin
          ctrl_r[conv_seq_pkg::done_bit] <= 1'b0;
        end
      end
      // RULE23 start high while busy
      if (trig_edge) begin
        ctrl_r[conv_seq_pkg::start_bit] <= 1'b1;
      end
      // RULE6 done set wins, start cleared unless free running
      if (done_evt) begin
        ctrl_r[conv_seq_pkg::done_bit] <= 1'b1;
        if (!free_run) begin
          ctrl_r[conv_seq_pkg::start_bit] <= 1'b0;
        end
      end
      if (!enable && !(req.wr && req.addr == conv_seq_pkg::ctrl_status_off)) begin
        ctrl_r[conv_seq_pkg::start_bit] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      isel_r <= conv_seq_pkg::input_select_rst;
      tcfg_r <= conv_seq_pkg::trigger_cfg_rst;
    end else if (req.wr) begin
      if (req.addr == conv_seq_pkg::input_select_off) begin
        isel_r <= req.wdata;
      end
      if (req.addr == conv_seq_pkg::trigger_cfg_off) begin
        tcfg_r <= req.wdata;
      end
    end
  end

  // ----------------------------------------
  // selection buffer
  // ----------------------------------------
  // RULE14 RULE15 RULE20 lock while converting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_active <= '0;
      ref_active  <= '0;
    end else if (state_r == conv_seq_pkg::st_idle || state_r == conv_seq_pkg::st_last) begin
      chan_active <= sel_tmp.chan_sel;
      ref_active  <= sel_tmp.ref_sel;
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  // RULE24 block between byte reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_lo_r <= '0;
      res_hi_r <= '0;
      block_r  <= 1'b0;
    end else begin
      if (done_evt && !block_r) begin
        res_lo_r <= sar_result[7:0];
        res_hi_r <= sar_result[9:8];
      end
      if (req.rd && req.addr == conv_seq_pkg::result_low_off) begin
        block_r <= 1'b1;
      end else if (req.rd && req.addr == conv_seq_pkg::result_high_off) begin
        block_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // read data and outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (req.rd) begin
      case (req.addr)
        conv_seq_pkg::ctrl_status_off:  rdata <= ctrl_r;
        conv_seq_pkg::input_select_off: rdata <= isel_r;
        conv_seq_pkg::result_low_off:   rdata <= res_lo_r;
        conv_seq_pkg::result_high_off:  rdata <= {6'h00, res_hi_r};
        conv_seq_pkg::trigger_cfg_off:  rdata <= tcfg_r;
        conv_seq_pkg::active_sel_off:   rdata <= {ref_active, 1'b0, chan_active};
        default:                        rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_hold         <= 1'b0;
      conv_busy           <= 1'b0;
      analog_en           <= 1'b0;
      upper_pin_analog_en <= 4'h0;
    end else begin
      sample_hold <= (state_r == conv_seq_pkg::st_conv) && tick && (cnt_r == sh_r);
      conv_busy   <= (state_r != conv_seq_pkg::st_idle);
      analog_en   <= enable;
      // RULE19 test port override
      upper_pin_analog_en <= test_s_r ? 4'h0 : 4'hf;
    end
  end

endmodule

// ### dv/conv_seq_sva.sv
// port checker for the conversion sequencer
// assumes bind from tb_top, one clk domain
`timescale 1ns/100ps
module conv_seq_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       test_port_en,
  input wire logic       sample_hold,
  input wire logic       conv_busy,
  input wire logic       analog_en,
  input wire logic [4:0] chan_active,
  input wire logic [3:0] upper_pin_analog_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----
  // sequences
  // ----
  sequence en_wr_s;
    wr && addr == 4'h0 && wdata[7];
  endsequence
  sequence dis_wr_s;
    wr && addr == 4'h0 && !wdata[7];
  endsequence
  sequence locked_s;
    ($stable(chan_active) || !analog_en) [*8];
  endsequence
  // ----
  // assertions
  // ----
  rd_quiet_a:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not zero");
  en_on_a:
    assert property (en_wr_s |-> ##2 analog_en) else $error("enable not followed");
  en_off_a:
    assert property (dis_wr_s |-> ##2 !analog_en) else $error("disable not followed");
  idle_off_a:
    assert property ((!analog_en) [*3] |-> !conv_busy && !sample_hold)
      else $error("activity while disabled");
  pins_off_a:
    assert property (test_port_en [*5] |-> upper_pin_analog_en == 4'h0)
      else $error("pins kept with test port");
  pins_on_a:
    assert property ((!test_port_en) [*5] |-> upper_pin_analog_en == 4'hf)
      else $error("pins lost without test port");
  sh_pulse_a:
    assert property (sample_hold |=> !sample_hold) else $error("sample pulse too long");
  sh_busy_a:
    assert property (sample_hold |-> conv_busy) else $error("sample outside conversion");
  sel_lock_a:
    assert property (sample_hold |=> locked_s) else $error("selection moved in conversion");
  busy_min_a:
    assert property ($rose(conv_busy) |-> (conv_busy || !analog_en) [*8])
      else $error("conversion too short");
endmodule

// ### dv/trig_src_model.sv
// trigger source and analog result stand-in
// assumes fire is a one-clk pulse from the bench
`timescale 1ns/100ps
module trig_src_model #(
  parameter int trig_n = 8
) (
  input  wire logic              clk,
  input  wire logic              fire,
  input  wire logic [2:0]        src,
  input  wire logic [9:0]        level,
  output logic      [trig_n-1:0] trig_in,
  output logic      [9:0]        sar_result
);
  logic [2:0] hold_r = 3'h0;
  always @(posedge clk) begin
    if (fire) begin
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  always_comb begin
    trig_in = '0;
    trig_in[src] = (hold_r != 3'h0);
  end
  assign sar_result = level;
endmodule

// ### dv/tb_top.sv
// self-checking bench for the conversion sequencer
// assumes conv_seq, checker and trigger model compiled first
`timescale 1ns/100ps
module tb_top;
  logic       clk;
  logic       rst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] trig_in;
  logic [9:0] sar_result;
  logic       test_port_en;
  logic       sample_hold;
  logic       conv_busy;
  logic       analog_en;
  logic [4:0] chan_active;
  logic [1:0] ref_active;
  logic [3:0] upper_pin_analog_en;
  logic       fire;
  logic [2:0] src;
  logic [9:0] level;
  logic [7:0] v;
  int         fails;
  int         samples_checked;
  int         cyc;
  int         blen;
  int         fire_t;
  int         t0;
  int         sh_t[$];
  int         bl[$];

  conv_seq #(.trig_n(8)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .trig_in(trig_in), .sar_result(sar_result),
    .test_port_en(test_port_en), .sample_hold(sample_hold), .conv_busy(conv_busy),
    .analog_en(analog_en), .chan_active(chan_active), .ref_active(ref_active),
    .upper_pin_analog_en(upper_pin_analog_en));
  trig_src_model #(.trig_n(8)) ptr (.clk(clk), .fire(fire), .src(src), .level(level),
    .trig_in(trig_in), .sar_result(sar_result));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // monitor and timeout
  // ----
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sample_hold === 1'b1) sh_t.push_back(cyc);
    if (conv_busy === 1'b1) begin
      blen <= blen + 1;
    end else if (blen != 0) begin
      bl.push_back(blen);
      blen <= 0;
    end
    if (cyc > 30000) begin
      fails++;
      close_out();
    end
  end
  // ----
  // tasks
  // ----
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic in_range(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 400; i++) begin
      rd_reg(4'h0, v);
      if (v[4] === 1'b1) break;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_trig();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    test_port_en = 1'b0;
    fire = 1'b0;
    src = 3'h1;
    level = 10'h2a5;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[3:0], v);
      cmp(v, 8'h00);
    end
    $display("test reset_values done");
    wr_reg(4'h1, 8'h45);
    wr_reg(4'h0, 8'h81);
    wr_reg(4'h0, 8'hc1);
    wait_done();
    in_range(bl[$], 50, 53);
    cmp(v & 8'hd0, 8'h90);
    rd_reg(4'h2, v);
    cmp(v, 8'ha5);
    rd_reg(4'h3, v);
    cmp(v, 8'h02);
    cmp({1'b0, ref_active, chan_active}, 8'h25);
    $display("test first_conv done");
    level <= 10'h15a;
    wr_reg(4'h0, 8'hd1);
    wr_reg(4'h1, 8'h83);
    rd_reg(4'h0, v);
    cmp(v & 8'h40, 8'h40);
    cmp({1'b0, ref_active, chan_active}, 8'h25);
    wait_done();
    in_range(bl[$], 26, 29);
    cmp({1'b0, ref_active, chan_active}, 8'h43);
    $display("test normal_conv done");
    rd_reg(4'h2, v);
    cmp(v, 8'h5a);
    level <= 10'h0f0;
    wr_reg(4'h0, 8'hd1);
    wait_done();
    cmp(v & 8'h10, 8'h10);
    rd_reg(4'h3, v);
    cmp(v, 8'h01);
    rd_reg(4'h2, v);
    cmp(v, 8'h5a);
    $display("test result_lock done");
    wr_reg(4'h0, 8'hd2);
    wait_done();
    in_range(bl[$], 52, 57);
    $display("test divide done");
    test_port_en <= 1'b1;
    repeat (6) @(posedge clk);
    cmp({4'h0, upper_pin_analog_en}, 8'h00);
    test_port_en <= 1'b0;
    repeat (6) @(posedge clk);
    cmp({4'h0, upper_pin_analog_en}, 8'h0f);
    $display("test test_port done");
    wr_reg(4'h4, 8'h01);
    wr_reg(4'h0, 8'hb1);
    t0 = sh_t.size();
    fire_t = cyc;
    pulse_trig();
    repeat (12) @(posedge clk);
    pulse_trig();
    repeat (80) @(posedge clk);
    in_range(sh_t.size() - t0, 1, 1);
    in_range(sh_t[t0] - fire_t, 4, 12);
    rd_reg(4'h0, v);
    cmp(v & 8'h50, 8'h10);
    $display("test auto_trigger done");
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h0, 8'hf1);
    repeat (120) @(posedge clk);
    rd_reg(4'h0, v);
    cmp(v & 8'h40, 8'h40);
    in_range(sh_t[$] - sh_t[$-1], 26, 26);
    $display("test free_running done");
    wr_reg(4'h0, 8'h01);
    wr_reg(4'h4, 8'h80);
    wr_reg(4'h0, 8'hf1);
    repeat (150) @(posedge clk);
    in_range(sh_t[$] - sh_t[$-1], 28, 28);
    wr_reg(4'h0, 8'h00);
    repeat (8) @(posedge clk);
    cmp({7'h00, conv_busy}, 8'h00);
    $display("test differential done");
    wr_reg(4'h0, 8'hd1);
    wait_done();
    in_range(bl[$], 51, 52);
    wr_reg(4'h0, 8'hd1);
    wait_done();
    in_range(bl[$], 27, 30);
    $display("test diff_single done");
    close_out();
  end
endmodule

bind conv_seq conv_seq_sva chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .test_port_en(test_port_en), .sample_hold(sample_hold),
  .conv_busy(conv_busy), .analog_en(analog_en), .chan_active(chan_active),
  .upper_pin_analog_en(upper_pin_analog_en));
